/* hdl/mcp_pkg.sv */
// What this block does
// - Answer I/O at ports F8, FA, FC only.
// - Busy asserted while an instruction executes.
// - Detect six exception conditions.
// - Unmasked exception raises error; masked does not.
// - Error raises interrupt 13, latches busy.
// - Zero byte to F0 clears busy latch, interrupt.
// - Reset or zero byte to F1 gives real mode.
// - Protected mode by escape; zero F1 leaves it.
// - Runs from the host's clock generator.
// - Computes while the host continues.
// - Eight 80-bit data registers, stack or fixed.
// - Stack arithmetic uses only top two.
// - Seven numeric formats supported.
package mcp_pkg;
  localparam logic [15:0] MCP_PORT_CLEAR = 16'h00F0;
  localparam logic [15:0] MCP_PORT_RESET = 16'h00F1;
  localparam logic [15:0] MCP_PORT_A = 16'h00F8;
  localparam logic [15:0] MCP_PORT_B = 16'h00FA;
  localparam logic [15:0] MCP_PORT_C = 16'h00FC;
  localparam int MCP_NREG = 8;
  localparam int MCP_REG_W = 80;
  localparam int MCP_NEXC = 6;
  localparam logic [5:0] MCP_MASK_RESET = 6'h3F;
  localparam logic [7:0] MCP_EXEC_CYCLES = 8'h08;
  localparam logic [2:0] MCP_TOP_RESET = 3'h0;
  // Opcode word written to port A: [15:12] operation, [11:9] format, [8:6] register.
  localparam logic [3:0] MCP_OP_NOP = 4'h0;
  localparam logic [3:0] MCP_OP_LOAD = 4'h1;
  localparam logic [3:0] MCP_OP_STORE = 4'h2;
  localparam logic [3:0] MCP_OP_ADD = 4'h3;
  localparam logic [3:0] MCP_OP_SUB = 4'h4;
  localparam logic [3:0] MCP_OP_DIV = 4'h5;
  localparam logic [3:0] MCP_OP_ENTER_PROT = 4'h6;
  localparam logic [3:0] MCP_OP_LDMASK = 4'h7;
  localparam logic [3:0] MCP_OP_LDREG = 4'h8;
  localparam logic [3:0] MCP_OP_POP = 4'h9;
  // Seven formats.
  localparam logic [2:0] MCP_FMT_I16 = 3'h0;
  localparam logic [2:0] MCP_FMT_I32 = 3'h1;
  localparam logic [2:0] MCP_FMT_I64 = 3'h2;
  localparam logic [2:0] MCP_FMT_BCD = 3'h3;
  localparam logic [2:0] MCP_FMT_R32 = 3'h4;
  localparam logic [2:0] MCP_FMT_R64 = 3'h5;
  localparam logic [2:0] MCP_FMT_R80 = 3'h6;
  // Exception bit positions.
  localparam int MCP_EX_INV = 0;
  localparam int MCP_EX_DEN = 1;
  localparam int MCP_EX_ZDIV = 2;
  localparam int MCP_EX_OVF = 3;
  localparam int MCP_EX_UNF = 4;
  localparam int MCP_EX_PREC = 5;
  typedef enum {MCP_IDLE, MCP_EXEC} mcp_state_t;
endpackage

/* hdl/mcp_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mcp_core_if;
  logic start;
  logic [15:0] opcode;
  logic [63:0] operand;
  logic done;
  logic [5:0] exc;
  logic [63:0] result;
  modport ctl (output start, output opcode, output operand, input done, input exc,
    input result);
  modport core (input start, input opcode, input operand, output done, output exc,
    output result);
endinterface
`default_nettype wire

/* hdl/mcp_core.sv */
`timescale 1ns/1ps
`default_nettype none
module mcp_core
  import mcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  mcp_core_if.core bus
);
  logic [MCP_REG_W-1:0] regs [MCP_NREG];
  logic [2:0] top;
  logic [7:0] count;
  logic busy;
  logic [15:0] op_q;
  logic [63:0] arg_q;
  wire [3:0] op = op_q[15:12];
  wire [2:0] fmt = op_q[11:9];
  wire [2:0] idx = op_q[8:6];
  wire [2:0] top1 = top + 3'h1;
  wire [MCP_REG_W-1:0] st0 = regs[top];
  wire [MCP_REG_W-1:0] st1 = regs[top1];
  wire [MCP_REG_W-1:0] sum = st0 + st1;
  wire [MCP_REG_W-1:0] dif = st1 - st0;
  wire [MCP_REG_W-1:0] quo = (st0 == '0) ? '0 : st1 / st0;
  wire carry = (sum < st0);
  logic [MCP_REG_W-1:0] loaded;
  always_comb
  begin
    case (fmt)
      MCP_FMT_I16: loaded = {{64{arg_q[15]}}, arg_q[15:0]};
      MCP_FMT_I32, MCP_FMT_R32: loaded = {{48{arg_q[31]}}, arg_q[31:0]};
      MCP_FMT_I64, MCP_FMT_R64, MCP_FMT_R80: loaded = {{16{arg_q[63]}}, arg_q};
      MCP_FMT_BCD: loaded = {16'h0000, arg_q};
      default: loaded = '0;
    endcase
  end
  logic [5:0] exc_n;
  always_comb
  begin
    exc_n = '0;
    exc_n[MCP_EX_INV] = (fmt == 3'h7) && (op == MCP_OP_LOAD);
    exc_n[MCP_EX_DEN] = (op == MCP_OP_LOAD) && (loaded == '0) && (arg_q != '0);
    exc_n[MCP_EX_ZDIV] = (op == MCP_OP_DIV) && (st0 == '0);
    exc_n[MCP_EX_OVF] = (op == MCP_OP_ADD) && carry;
    exc_n[MCP_EX_UNF] = (op == MCP_OP_SUB) && (st1 < st0);
    exc_n[MCP_EX_PREC] = (op == MCP_OP_DIV) && (st0 != '0) && ((st1 % st0) != '0);
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      top <= MCP_TOP_RESET;
      count <= '0;
      busy <= 1'b0;
      op_q <= '0;
      arg_q <= '0;
      bus.done <= 1'b0;
      bus.exc <= '0;
      bus.result <= '0;
    end
    else
    begin
      bus.done <= 1'b0;
      bus.exc <= '0;
      if (bus.start && !busy)
      begin
        busy <= 1'b1;
        count <= MCP_EXEC_CYCLES;
        op_q <= bus.opcode;
        arg_q <= bus.operand;
      end
      else if (busy && count != 8'h01)
        count <= count - 8'h01;
      else if (busy)
      begin
        busy <= 1'b0;
        bus.done <= 1'b1;
        bus.exc <= exc_n;
        case (op)
          MCP_OP_LOAD: top <= top - 3'h1;
          MCP_OP_STORE: bus.result <= st0[63:0];
          MCP_OP_LDREG: bus.result <= regs[idx][63:0];
          MCP_OP_ADD, MCP_OP_SUB, MCP_OP_DIV, MCP_OP_POP: top <= top1;
          default: top <= top;
        endcase
      end
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst && busy && count == 8'h01)
    begin
      case (op)
        MCP_OP_LOAD: regs[top - 3'h1] <= loaded;
        MCP_OP_ADD: regs[top1] <= sum;
        MCP_OP_SUB: regs[top1] <= dif;
        MCP_OP_DIV: regs[top1] <= quo;
        default: regs[top] <= st0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* hdl/mcp_attach.sv */
`timescale 1ns/1ps
`default_nettype none
module mcp_attach
  import mcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_hit,
  output logic busy,
  output logic error,
  output logic irq13,
  output logic protected_mode
);
  mcp_core_if cif();
  mcp_core u_core (
    .clk(clk),
    .rst(rst),
    .bus(cif)
  );
  mcp_state_t state;
  logic [15:0] opcode_q;
  logic [63:0] operand_q;
  logic [63:0] result_q;
  logic [5:0] mask;
  logic [5:0] pending;
  logic busy_latch;
  logic start;
  wire sel_a = io_addr == MCP_PORT_A;
  wire sel_b = io_addr == MCP_PORT_B;
  wire sel_c = io_addr == MCP_PORT_C;
  wire sel_any = sel_a || sel_b || sel_c;
  wire clr_wr = io_wr && io_addr == MCP_PORT_CLEAR && io_wdata[7:0] == 8'h00;
  wire rst_wr = io_wr && io_addr == MCP_PORT_RESET && io_wdata[7:0] == 8'h00;
  wire raise = cif.done && |(cif.exc & ~mask);
  wire [3:0] opk = opcode_q[15:12];
  // Mask loads and protected-mode entry take effect at completion so they stay in order.
  wire do_enter_prot = cif.done && opk == MCP_OP_ENTER_PROT;
  wire do_ldmask = cif.done && opk == MCP_OP_LDMASK;
  assign cif.start = start;
  assign cif.opcode = opcode_q;
  assign cif.operand = operand_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= MCP_IDLE;
      opcode_q <= '0;
      operand_q <= '0;
      result_q <= '0;
      start <= 1'b0;
      io_rdata <= '0;
      io_hit <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      io_hit <= (io_wr || io_rd) && sel_any;
      if (io_wr && sel_b)
        operand_q <= {operand_q[47:0], io_wdata};
      if (io_rd && sel_c)
        result_q <= {16'h0000, result_q[63:16]};
      if (cif.done)
        result_q <= cif.result;
      if (io_rd)
        io_rdata <= sel_a ? {10'h000, pending} : sel_c ? result_q[15:0] :
          sel_b ? {15'h0000, busy} : 16'h0000;
      case (state)
        MCP_IDLE:
          if (io_wr && sel_a && !busy_latch)
          begin
            opcode_q <= io_wdata;
            start <= 1'b1;
            state <= MCP_EXEC;
          end
        MCP_EXEC:
          if (cif.done)
            state <= MCP_IDLE;
        default: state <= MCP_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask <= MCP_MASK_RESET;
      pending <= '0;
      busy_latch <= 1'b0;
      error <= 1'b0;
      irq13 <= 1'b0;
      busy <= 1'b0;
      protected_mode <= 1'b0;
    end
    else
    begin
      if (do_ldmask)
        mask <= operand_q[5:0];
      if (cif.done)
        pending <= pending | cif.exc;
      error <= raise || (error && !clr_wr);
      busy_latch <= raise || (busy_latch && !clr_wr);
      irq13 <= raise || (irq13 && !clr_wr);
      busy <= (state == MCP_EXEC && !cif.done) || start || raise ||
        (io_wr && sel_a && state == MCP_IDLE && !busy_latch) || (busy_latch && !clr_wr);
      if (do_enter_prot)
        protected_mode <= 1'b1;
      else if (rst_wr)
        protected_mode <= 1'b0;
    end
  end
  AST_ERR_IRQ: assert property (@(posedge clk) disable iff (rst)
    raise |=> irq13 && busy && error) else $error("error did not latch irq");
  AST_CLR: assert property (@(posedge clk) disable iff (rst)
    clr_wr && !raise |=> !irq13 && !busy_latch) else $error("clear failed");
  AST_NZ: assert property (@(posedge clk) disable iff (rst)
    io_wr && io_addr == MCP_PORT_CLEAR && io_wdata[7:0] != 8'h00 && irq13 |=> irq13)
    else $error("nonzero clear acted");
  AST_MASK: assert property (@(posedge clk) disable iff (rst)
    cif.done && !(|(cif.exc & ~mask)) && !error |=> !error) else $error("masked error");
  sequence s_issue;
    start;
  endsequence
  AST_BUSY: assert property (@(posedge clk) disable iff (rst)
    s_issue |-> busy [*7]) else $error("busy dropped early");
  AST_PM: assert property (@(posedge clk) disable iff (rst)
    do_enter_prot |=> protected_mode) else $error("no protected mode");
  AST_RM: assert property (@(posedge clk) disable iff (rst)
    rst_wr && !do_enter_prot |=> !protected_mode) else $error("still protected");
  AST_HIT: assert property (@(posedge clk) disable iff (rst)
    io_rd && !sel_any |=> !io_hit) else $error("stray hit");

  AST_HIT_WR: assert property (@(posedge clk) disable iff (rst)
    io_wr && sel_any |=> io_hit)
    else $error("missed write hit");

  AST_RD_OFF: assert property (@(posedge clk) disable iff (rst)
    io_rd && !sel_any |=> io_rdata == 16'h0000)
    else $error("stray read data");

  AST_RD_B: assert property (@(posedge clk) disable iff (rst)
    io_rd && sel_b |=> io_rdata[15:1] == 15'h0000)
    else $error("bad busy word");

  AST_RD_A: assert property (@(posedge clk) disable iff (rst)
    io_rd && sel_a |=> io_rdata[15:6] == 10'h000)
    else $error("bad pending word");

  AST_PEND: assert property (@(posedge clk) disable iff (rst)
    cif.done |=> (pending & $past(cif.exc)) == $past(cif.exc))
    else $error("exception lost");

  AST_IRQ_EQ: assert property (@(posedge clk) disable iff (rst)
    error == irq13)
    else $error("irq and error differ");

  AST_LATCH: assert property (@(posedge clk) disable iff (rst)
    busy_latch |-> busy)
    else $error("latch without busy");

  AST_NO_ISSUE: assert property (@(posedge clk) disable iff (rst)
    busy_latch && io_wr && sel_a |=> !start)
    else $error("issued while latched");

  AST_ERR_HOLD: assert property (@(posedge clk) disable iff (rst)
    error && !clr_wr |=> error)
    else $error("error dropped");

  AST_DROP: assert property (@(posedge clk) disable iff (rst)
    cif.done && !raise && !busy_latch |=> !busy)
    else $error("busy stuck");

  AST_NZ_MODE: assert property (@(posedge clk) disable iff (rst)
    io_wr && io_addr == MCP_PORT_RESET && io_wdata[7:0] != 8'h00 && protected_mode |=> protected_mode)
    else $error("nonzero reset acted");

  AST_MODE_ST: assert property (@(posedge clk) disable iff (rst)
    !do_enter_prot && !rst_wr |=> protected_mode == $past(protected_mode))
    else $error("mode changed alone");

  AST_MASK_LD: assert property (@(posedge clk) disable iff (rst)
    do_ldmask |=> mask == $past(operand_q[5:0]))
    else $error("mask not loaded");

  AST_START1: assert property (@(posedge clk) disable iff (rst)
    start |=> !start)
    else $error("double start");
endmodule
`default_nettype wire

/* tb/mcp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mcp_host
  import mcp_pkg::*;
(
  input wire logic clk,
  input wire logic busy,
  input wire logic [15:0] io_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [15:0] io_wdata
);
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
  end
  task automatic io_write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    #1;
    io_addr = addr;
    io_wdata = data;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    // A released bus shows the inverse, so stale values are never mistaken for live ones.
    io_addr = ~addr;
    io_wdata = ~data;
  endtask
  task automatic io_read(input logic [15:0] addr, output logic [15:0] data);
    @(posedge clk);
    #1;
    io_addr = addr;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    io_addr = ~addr;
    data = io_rdata;
  endtask
  task automatic wait_ready(output int cycles);
    cycles = 0;
    while (busy !== 1'b0 && cycles < 64)
    begin
      @(posedge clk);
      #1;
      cycles++;
    end
  endtask
endmodule
`default_nettype wire

/* tb/test_math_coprocessor_io_attach.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
  begin \
    checks_done++; \
    if ((act) !== (exp)) \
    begin \
      miscompares++; \
      $display("[FAIL] %0t: got %h want %h", $time, act, exp); \
    end \
  end
module test_math_coprocessor_io_attach;
  import mcp_pkg::*;
  logic clk;
  logic rst;
  logic io_wr;
  logic io_rd;
  logic [15:0] io_addr;
  logic [15:0] io_wdata;
  logic [15:0] io_rdata;
  logic io_hit;
  logic busy;
  logic error;
  logic irq13;
  logic protected_mode;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'h75d3;
  int exp_mode = 0;
  int n;
  logic [15:0] rd;
  mcp_attach mcp_attach_i (.clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .busy(busy), .error(error), .irq13(irq13), .protected_mode(protected_mode));
  mcp_host mcp_host_i (.clk(clk), .busy(busy), .io_rdata(io_rdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // Operand goes most significant word first, then the opcode word.
  task automatic run_op(input logic [3:0] code, input logic [2:0] fmt, input logic [63:0] opnd);
    for (int i = 3; i >= 0; i--)
      mcp_host_i.io_write(MCP_PORT_B, opnd[i*16 +: 16]);
    mcp_host_i.io_write(MCP_PORT_A, {code, fmt, 3'h0, 6'h00});
    `CHK(busy, 1'b1)
    mcp_host_i.wait_ready(n);
  endtask
  initial
  begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK({busy, error, irq13, protected_mode}, 4'h0)
    mcp_host_i.io_read(16'h00F4, rd);
    `CHK({io_hit, rd}, 17'h0_0000)
    mcp_host_i.io_read(MCP_PORT_C, rd);
    `CHK(io_hit, 1'b1)
    mcp_host_i.io_read(MCP_PORT_B, rd);
    `CHK({io_hit, rd[0]}, 2'h2)
    for (int f = 0; f < 7; f++)
    begin
      run_op(MCP_OP_LOAD, f[2:0], {$random(seed), $random(seed)});
      `CHK(n == 9 || n == 10, 1'b1)
    end
    run_op(MCP_OP_ENTER_PROT, MCP_FMT_R80, 64'h0000_0000_0000_0000);
    exp_mode = 1;
    `CHK(protected_mode, exp_mode[0])
    mcp_host_i.io_write(MCP_PORT_RESET, 16'h00A5);
    `CHK(protected_mode, exp_mode[0])
    mcp_host_i.io_write(MCP_PORT_RESET, 16'h0000);
    exp_mode = 0;
    `CHK(protected_mode, exp_mode[0])
    // unmasked fault latches busy.
    // A zero on top of the stack makes the divide a zero divide.
    run_op(MCP_OP_LOAD, MCP_FMT_I16, 64'h0000_0000_0000_0000);
    run_op(MCP_OP_LDMASK, MCP_FMT_I16, 64'h0000_0000_0000_0000);
    run_op(MCP_OP_DIV, MCP_FMT_I16, 64'h0000_0000_0000_0000);
    `CHK({busy, error, irq13}, 3'h7)
    mcp_host_i.io_read(MCP_PORT_A, rd);
    `CHK(rd[MCP_EX_ZDIV], 1'b1)
    mcp_host_i.io_write(MCP_PORT_CLEAR, 16'h0001);
    `CHK({busy, error, irq13}, 3'h7)
    mcp_host_i.io_write(MCP_PORT_CLEAR, 16'h0000);
    `CHK({busy, error, irq13}, 3'h0)
    run_op(MCP_OP_LDMASK, MCP_FMT_I16, {58'h0, MCP_MASK_RESET});
    run_op(MCP_OP_DIV, MCP_FMT_I16, 64'h0000_0000_0000_0000);
    `CHK({busy, error, irq13}, 3'h0)
    run_op(MCP_OP_LOAD, MCP_FMT_I16, 64'h0000_0000_0000_1234);
    run_op(MCP_OP_STORE, MCP_FMT_I16, 64'h0000_0000_0000_0000);
    mcp_host_i.io_read(MCP_PORT_C, rd);
    `CHK(rd, 16'h1234)
    mcp_host_i.io_read(MCP_PORT_C, rd);
    `CHK(rd, 16'h0000)
    report_and_stop();
  end
endmodule
`default_nettype wire
